// ===== rmsc_defines.vh
// Constants for the receive mixer and synthesizer configuration register bank
`ifndef RMSC_DEFINES_VH
`define RMSC_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RMSC_OFS_SOFT   7'h00
`define RMSC_OFS_PWR    7'h01
`define RMSC_OFS_INT    7'h02
`define RMSC_OFS_FRAC   7'h03
`define RMSC_OFS_MOD    7'h04
`define RMSC_OFS_PUMP   7'h20
`define RMSC_OFS_PD     7'h21
`define RMSC_OFS_LO     7'h22
`define RMSC_OFS_GAIN   7'h23
`define RMSC_OFS_XFMR   7'h30
`define RMSC_OFS_MIX    7'h31
`define RMSC_OFS_PD2    7'h40
`define RMSC_OFS_NOISE  7'h42
`define RMSC_OFS_SEED   7'h43
`define RMSC_NUM_REGS   14

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RMSC_RST_SOFT   16'h0000
`define RMSC_RST_PWR    16'h8b7f
`define RMSC_RST_INT    16'h0058
`define RMSC_RST_FRAC   16'h0250
`define RMSC_RST_MOD    16'h0600
`define RMSC_RST_PUMP   16'h0c26
`define RMSC_RST_PD     16'h0003
`define RMSC_RST_LO     16'h000a
`define RMSC_RST_GAIN   16'h0000
`define RMSC_RST_XFMR   16'h0000
`define RMSC_RST_MIX    16'h08ef
`define RMSC_RST_PD2    16'h0010
`define RMSC_RST_NOISE  16'h000e
`define RMSC_RST_SEED   16'h0001

// ----------------------------------------------------------------
// Implemented bit masks
// ----------------------------------------------------------------
`define RMSC_MSK_SOFT   16'h0000
`define RMSC_MSK_PWR    16'h8bbf
`define RMSC_MSK_INT    16'h0fff
`define RMSC_MSK_DIV    16'h07ff
`define RMSC_MSK_PUMP   16'h3c3f
`define RMSC_MSK_PD     16'h007f
`define RMSC_MSK_LO     16'h019f
`define RMSC_MSK_GAIN   16'h0fff
`define RMSC_MSK_XFMR   16'h00ee
`define RMSC_MSK_MIX    16'h0fef
`define RMSC_MSK_PD2    16'h007f
`define RMSC_MSK_NOISE  16'h000f
`define RMSC_MSK_SEED   16'hffff

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RMSC_B_SOFT     0
`define RMSC_B_LOREG    15
`define RMSC_B_IFAMP    11
`define RMSC_B_MIXER    9
`define RMSC_B_EXTLO    8
`define RMSC_B_LODRV    7
`define RMSC_B_REFBUF   5
`define RMSC_B_OSC      4
`define RMSC_B_DIVS     3
`define RMSC_B_PUMP     2
`define RMSC_B_OSCREG   1
`define RMSC_B_MAINREG  0
`define RMSC_B_INTMODE  11
`define RMSC_F_DIV      10:0
`define RMSC_F_PCODE    13:10
`define RMSC_B_BLDIR    5
`define RMSC_F_BLEED    4:0
`define RMSC_F_REFOUT   6:4
`define RMSC_B_PDPOL    3
`define RMSC_F_REFIN    2:0
`define RMSC_F_LODRV    8:7
`define RMSC_F_LODIV    4:3
`define RMSC_F_OSCSEL   2:0
`define RMSC_B_SWPIN    11
`define RMSC_F_RFIN     10:9
`define RMSC_F_RFATT    8:5
`define RMSC_F_IFATT    4:0
`define RMSC_F_COUT     7:5
`define RMSC_F_CIN      3:1
`define RMSC_F_MBIAS    11:9
`define RMSC_F_MRDAC    8:5
`define RMSC_F_MCDAC    3:0
`define RMSC_F_PD2      6:0
`define RMSC_F_NOISE    3:0

// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define RMSC_FRAME_BITS 5'd24
`define RMSC_HDR_LAST   5'd7
`define RMSC_DATA_LAST  5'd23

`endif

// ===== rmsc_host.sv
// Host model that runs frames on the three-wire serial port
`timescale 1ns/10ps
`default_nettype none
module rmsc_host (
	// Clock
	input  wire logic i_clk,
	// Device side of the data pin
	input  wire logic i_dev_sdio,
	input  wire logic i_dev_sdio_oe,
	// Serial pins
	output var logic  o_sclk,
	output var logic  o_cs_n,
	output wire logic o_sdio
);
	logic host_oe_q;
	logic host_bit_q;
	// Undriven line shows the opposite of the last bit so a stale value is never read
	assign o_sdio = i_dev_sdio_oe ? i_dev_sdio : (host_oe_q ? host_bit_q : ~host_bit_q);
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		host_oe_q = 1'b0;
		host_bit_q = 1'b0;
	end
	// hp is the clock high and low time in cycles; 4 is the fastest legal rate
	task automatic xfer(input logic rd, input logic [6:0] addr, input logic [15:0] wd,
		input int hp, output logic [15:0] rdata);
		logic [23:0] frame;
		int          k;
		frame = {rd, addr, wd};
		rdata = 16'h0000;
		@(posedge i_clk);
		o_cs_n <= 1'b0;
		for (k = 23; k >= 0; k--) begin
			host_oe_q  <= !rd || (k > 15);
			host_bit_q <= frame[k];
			repeat (hp) @(posedge i_clk);
			o_sclk <= 1'b1;
			if (rd && k <= 15)
				rdata[k] = o_sdio;
			repeat (hp) @(posedge i_clk);
			o_sclk <= 1'b0;
		end
		repeat (hp) @(posedge i_clk);
		o_cs_n    <= 1'b1;
		host_oe_q <= 1'b0;
		repeat (12) @(posedge i_clk);
	endtask
endmodule // rmsc_host
`default_nettype wire

// ===== rmsc_regs.v
// Configuration register bank with its three-wire serial port
`timescale 1ns/10ps
`default_nettype none
`include "rmsc_defines.vh"

module rmsc_regs (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_rst,

	// Serial port pins
	input  wire        i_sclk,
	input  wire        i_cs_n,
	input  wire        i_sdio,
	output wire        o_sdio,
	output wire        o_sdio_oe,

	// Soft reset indication
	output reg         o_soft_reset,

	// Block power enables
	output wire        o_lo_regulator_power,
	output wire        o_output_amplifier_power,
	output wire        o_mixer_power,
	output wire        o_external_lo_route_power,
	output wire        o_lo_driver_power,
	output wire        o_ref_buffer_power,
	output wire        o_oscillator_power,
	output wire        o_divider_power,
	output wire        o_pump_power,
	output wire        o_oscillator_regulator_power,
	output wire        o_main_regulator_power,

	// Feedback divider
	output wire        o_div_integer_mode,
	output wire [10:0] o_feedback_integer,
	output wire [10:0] o_feedback_fraction,
	output wire [10:0] o_feedback_modulus,

	// Charge pump
	output wire [3:0]  o_pump_current_code,
	output wire        o_pump_code_legal,
	output wire        o_bleed_source,
	output wire [4:0]  o_bleed_magnitude,

	// Phase detector and reference
	output wire [2:0]  o_ref_out_select,
	output wire        o_pd_negative,
	output wire [2:0]  o_ref_in_divide,
	output wire [6:0]  o_pd_control_two,

	// LO generation
	output wire [1:0]  o_lo_drive_level,
	output wire [1:0]  o_lo_divide,
	output wire [2:0]  o_osc_select,

	// Input switch and gain
	output wire        o_switch_pin_ctl,
	output wire [1:0]  o_rf_input_select,
	output wire [3:0]  o_rf_atten,
	output wire [4:0]  o_if_atten,

	// Input transformer and mixer tuning
	output wire [2:0]  o_xfmr_cout,
	output wire [2:0]  o_xfmr_cin,
	output wire [2:0]  o_mixer_bias,
	output wire [3:0]  o_mixer_rdac,
	output wire [3:0]  o_mixer_cdac,

	// Sigma-delta noise
	output wire [3:0]  o_noise_control,
	output wire [15:0] o_noise_seed
);

	// ----------------------------------------------------------------
	// Address decode helpers
	// ----------------------------------------------------------------
	// Returns {hit, index}; unmapped offsets give hit low
	function [4:0] rmsc_index;
		input [6:0] a;
		begin
			case (a)
			`RMSC_OFS_SOFT:  rmsc_index = 5'h10;
			`RMSC_OFS_PWR:   rmsc_index = 5'h11;
			`RMSC_OFS_INT:   rmsc_index = 5'h12;
			`RMSC_OFS_FRAC:  rmsc_index = 5'h13;
			`RMSC_OFS_MOD:   rmsc_index = 5'h14;
			`RMSC_OFS_PUMP:  rmsc_index = 5'h15;
			`RMSC_OFS_PD:    rmsc_index = 5'h16;
			`RMSC_OFS_LO:    rmsc_index = 5'h17;
			`RMSC_OFS_GAIN:  rmsc_index = 5'h18;
			`RMSC_OFS_XFMR:  rmsc_index = 5'h19;
			`RMSC_OFS_MIX:   rmsc_index = 5'h1a;
			`RMSC_OFS_PD2:   rmsc_index = 5'h1b;
			`RMSC_OFS_NOISE: rmsc_index = 5'h1c;
			`RMSC_OFS_SEED:  rmsc_index = 5'h1d;
			default:         rmsc_index = 5'h00;
			endcase
		end
	endfunction

	// Bits that exist; everything else is reserved and keeps its reset value
	function [15:0] rmsc_mask;
		input [3:0] i;
		begin
			case (i)
			4'h1:    rmsc_mask = `RMSC_MSK_PWR;
			4'h2:    rmsc_mask = `RMSC_MSK_INT;
			4'h3:    rmsc_mask = `RMSC_MSK_DIV;
			4'h4:    rmsc_mask = `RMSC_MSK_DIV;
			4'h5:    rmsc_mask = `RMSC_MSK_PUMP;
			4'h6:    rmsc_mask = `RMSC_MSK_PD;
			4'h7:    rmsc_mask = `RMSC_MSK_LO;
			4'h8:    rmsc_mask = `RMSC_MSK_GAIN;
			4'h9:    rmsc_mask = `RMSC_MSK_XFMR;
			4'ha:    rmsc_mask = `RMSC_MSK_MIX;
			4'hb:    rmsc_mask = `RMSC_MSK_PD2;
			4'hc:    rmsc_mask = `RMSC_MSK_NOISE;
			4'hd:    rmsc_mask = `RMSC_MSK_SEED;
			default: rmsc_mask = `RMSC_MSK_SOFT;
			endcase
		end
	endfunction

	function [15:0] rmsc_default;
		input [3:0] i;
		begin
			case (i)
			4'h1:    rmsc_default = `RMSC_RST_PWR;
			4'h2:    rmsc_default = `RMSC_RST_INT;
			4'h3:    rmsc_default = `RMSC_RST_FRAC;
			4'h4:    rmsc_default = `RMSC_RST_MOD;
			4'h5:    rmsc_default = `RMSC_RST_PUMP;
			4'h6:    rmsc_default = `RMSC_RST_PD;
			4'h7:    rmsc_default = `RMSC_RST_LO;
			4'h8:    rmsc_default = `RMSC_RST_GAIN;
			4'h9:    rmsc_default = `RMSC_RST_XFMR;
			4'ha:    rmsc_default = `RMSC_RST_MIX;
			4'hb:    rmsc_default = `RMSC_RST_PD2;
			4'hc:    rmsc_default = `RMSC_RST_NOISE;
			4'hd:    rmsc_default = `RMSC_RST_SEED;
			default: rmsc_default = `RMSC_RST_SOFT;
			endcase
		end
	endfunction

	// Reserved bits keep their reset value whatever is written: zero everywhere
	// except bit 6 of the power register, which resets to one
	function [15:0] rmsc_merge;
		input [3:0]  i;
		input [15:0] d;
		begin
			rmsc_merge = (d & rmsc_mask(i))
			             | (rmsc_default(i) & ~rmsc_mask(i));
		end
	endfunction

	// Only the thermometer codes name a defined pump current
	function rmsc_legal;
		input [3:0] c;
		begin
			case (c)
			4'h1:    rmsc_legal = 1'b1;
			4'h3:    rmsc_legal = 1'b1;
			4'h7:    rmsc_legal = 1'b1;
			4'hf:    rmsc_legal = 1'b1;
			default: rmsc_legal = 1'b0;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// Serial port
	// ----------------------------------------------------------------
	wire [6:0]  addr;
	wire [15:0] wdata;
	wire        wr_stb;
	wire        rd_stb;
	reg  [15:0] rdata_q;

	rmsc_serial u_serial (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_sclk    (i_sclk),
		.i_cs_n    (i_cs_n),
		.i_sdio    (i_sdio),
		.o_sdio    (o_sdio),
		.o_sdio_oe (o_sdio_oe),
		.i_rdata   (rdata_q),
		.o_addr    (addr),
		.o_wdata   (wdata),
		.o_wr_stb  (wr_stb),
		.o_rd_stb  (rd_stb)
	);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	// Index 0 is the write-only trigger and never holds a one
	reg  [15:0] regs_q [0:`RMSC_NUM_REGS-1];
	wire [4:0]  wsel;
	wire [4:0]  rsel;
	wire        soft_hit;
	integer     k;

	// Reads and writes share the offset latched from the frame header
	assign wsel = rmsc_index(addr);
	assign rsel = rmsc_index(addr);

	// Only a one in bit 0 triggers; a zero write to 0x00 does nothing
	assign soft_hit = wr_stb && addr == `RMSC_OFS_SOFT
	                  && wdata[`RMSC_B_SOFT];

	// Soft reset reloads the same defaults as the pin reset
	always @(posedge i_clk) begin
		if (i_rst || soft_hit) begin
			for (k = 0; k < `RMSC_NUM_REGS; k = k + 1) begin
				regs_q[k] <= rmsc_default(k[3:0]);
			end
		end else if (wr_stb && wsel[4]) begin
			regs_q[wsel[3:0]] <= rmsc_merge(wsel[3:0], wdata);
		end
	end

	// The pulse lands with the reloaded defaults, one cycle after the strobe
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_soft_reset <= 1'b0;
		end else begin
			o_soft_reset <= soft_hit;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Write-only soft reset and unmapped offsets both read zero
	// Stored reserved bits already hold their reset value, so no read mask
	always @(posedge i_clk) begin
		if (i_rst) begin
			rdata_q <= 16'h0000;
		end else if (rd_stb) begin
			if (rsel[4])
				rdata_q <= regs_q[rsel[3:0]];
			else
				rdata_q <= 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// Field outputs
	// ----------------------------------------------------------------
	// Bit 6 of the power register is reserved and drives no output
	assign o_lo_regulator_power         = regs_q[1][`RMSC_B_LOREG];
	assign o_output_amplifier_power     = regs_q[1][`RMSC_B_IFAMP];
	assign o_mixer_power                = regs_q[1][`RMSC_B_MIXER];
	assign o_external_lo_route_power    = regs_q[1][`RMSC_B_EXTLO];
	assign o_lo_driver_power            = regs_q[1][`RMSC_B_LODRV];
	assign o_ref_buffer_power           = regs_q[1][`RMSC_B_REFBUF];
	assign o_oscillator_power           = regs_q[1][`RMSC_B_OSC];
	assign o_divider_power              = regs_q[1][`RMSC_B_DIVS];
	assign o_pump_power                 = regs_q[1][`RMSC_B_PUMP];
	assign o_oscillator_regulator_power = regs_q[1][`RMSC_B_OSCREG];
	assign o_main_regulator_power       = regs_q[1][`RMSC_B_MAINREG];

	assign o_div_integer_mode  = regs_q[2][`RMSC_B_INTMODE];
	assign o_feedback_integer  = regs_q[2][`RMSC_F_DIV];
	assign o_feedback_fraction = regs_q[3][`RMSC_F_DIV];
	assign o_feedback_modulus  = regs_q[4][`RMSC_F_DIV];

	// Legal flag is combinational from the stored code
	assign o_pump_current_code = regs_q[5][`RMSC_F_PCODE];
	assign o_pump_code_legal   = rmsc_legal(o_pump_current_code);
	assign o_bleed_source      = regs_q[5][`RMSC_B_BLDIR];
	assign o_bleed_magnitude   = regs_q[5][`RMSC_F_BLEED];

	assign o_ref_out_select = regs_q[6][`RMSC_F_REFOUT];
	assign o_pd_negative    = regs_q[6][`RMSC_B_PDPOL];
	assign o_ref_in_divide  = regs_q[6][`RMSC_F_REFIN];
	assign o_pd_control_two = regs_q[11][`RMSC_F_PD2];

	assign o_lo_drive_level = regs_q[7][`RMSC_F_LODRV];
	assign o_lo_divide      = regs_q[7][`RMSC_F_LODIV];
	assign o_osc_select     = regs_q[7][`RMSC_F_OSCSEL];

	assign o_switch_pin_ctl  = regs_q[8][`RMSC_B_SWPIN];
	assign o_rf_input_select = regs_q[8][`RMSC_F_RFIN];
	assign o_rf_atten        = regs_q[8][`RMSC_F_RFATT];
	assign o_if_atten        = regs_q[8][`RMSC_F_IFATT];

	assign o_xfmr_cout  = regs_q[9][`RMSC_F_COUT];
	assign o_xfmr_cin   = regs_q[9][`RMSC_F_CIN];
	assign o_mixer_bias = regs_q[10][`RMSC_F_MBIAS];
	assign o_mixer_rdac = regs_q[10][`RMSC_F_MRDAC];
	assign o_mixer_cdac = regs_q[10][`RMSC_F_MCDAC];

	assign o_noise_control = regs_q[12][`RMSC_F_NOISE];
	assign o_noise_seed    = regs_q[13];

endmodule // rmsc_regs

`default_nettype wire

// ===== rmsc_regs_asserts.sv
// Concurrent checks on the configuration register bank outputs
`timescale 1ns/10ps
`default_nettype none
module rmsc_regs_checker (
	// Clock and reset
	input wire logic        i_clk,
	input wire logic        i_rst,
	// Watched outputs
	input wire logic        o_soft_reset,
	input wire logic        o_lo_regulator_power,
	input wire logic        o_output_amplifier_power,
	input wire logic        o_mixer_power,
	input wire logic        o_external_lo_route_power,
	input wire logic        o_lo_driver_power,
	input wire logic        o_ref_buffer_power,
	input wire logic        o_oscillator_power,
	input wire logic        o_divider_power,
	input wire logic        o_pump_power,
	input wire logic        o_oscillator_regulator_power,
	input wire logic        o_main_regulator_power,
	input wire logic        o_div_integer_mode,
	input wire logic [10:0] o_feedback_integer,
	input wire logic [10:0] o_feedback_fraction,
	input wire logic [10:0] o_feedback_modulus,
	input wire logic [3:0]  o_pump_current_code,
	input wire logic        o_pump_code_legal,
	input wire logic        o_bleed_source,
	input wire logic [4:0]  o_bleed_magnitude
);
	// Power enables placed at their register bit positions, reserved bits zero
	wire [15:0] pwr_w = {o_lo_regulator_power, 3'h0, o_output_amplifier_power, 1'b0,
		o_mixer_power, o_external_lo_route_power, o_lo_driver_power, 1'b0, o_ref_buffer_power,
		o_oscillator_power, o_divider_power, o_pump_power, o_oscillator_regulator_power,
		o_main_regulator_power};
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	property p_rst_pwr; $fell(i_rst) |-> pwr_w == 16'h8b3f; endproperty
	a_rst_pwr: assert property (p_rst_pwr) else $error("power enables off default");
	// No frame can commit within eight cycles of release
	property p_rst_pump; $fell(i_rst) |-> o_pump_power [*8]; endproperty
	a_rst_pump: assert property (p_rst_pump) else $error("pump power not on");
	property p_rst_extlo; $fell(i_rst) |-> o_external_lo_route_power; endproperty
	a_rst_extlo: assert property (p_rst_extlo) else $error("external route off");
	property p_rst_mode;
		$fell(i_rst) |-> !o_div_integer_mode && o_feedback_integer == 11'h058;
	endproperty
	a_rst_mode: assert property (p_rst_mode) else $error("divider mode or integer");
	property p_rst_cp; $fell(i_rst) |-> o_pump_current_code == 4'h3 && o_pump_code_legal; endproperty
	a_rst_cp: assert property (p_rst_cp) else $error("pump current code off default");
	property p_code_legal;
		o_pump_code_legal == (o_pump_current_code inside {4'h1, 4'h3, 4'h7, 4'hf});
	endproperty
	a_code_legal: assert property (p_code_legal) else $error("legal flag wrong");
	property p_rst_bleed; $fell(i_rst) |-> o_bleed_source && o_bleed_magnitude == 5'h06; endproperty
	a_rst_bleed: assert property (p_rst_bleed) else $error("bleed off default");
	property p_soft_pulse; o_soft_reset |=> !o_soft_reset; endproperty
	a_soft_pulse: assert property (p_soft_pulse) else $error("soft pulse too long");
	property p_soft_pwr;
		o_soft_reset |-> pwr_w == 16'h8b3f && !o_div_integer_mode && o_feedback_integer == 11'h058;
	endproperty
	a_soft_pwr: assert property (p_soft_pwr) else $error("soft reset missed power");
	property p_soft_div;
		o_soft_reset |-> {o_feedback_fraction, o_feedback_modulus} == {11'h250, 11'h600};
	endproperty
	a_soft_div: assert property (p_soft_div) else $error("soft reset missed divider");
endmodule // rmsc_regs_checker

bind rmsc_regs rmsc_regs_checker u_checker (
	.i_clk(i_clk), .i_rst(i_rst), .o_soft_reset(o_soft_reset),
	.o_lo_regulator_power(o_lo_regulator_power),
	.o_output_amplifier_power(o_output_amplifier_power), .o_mixer_power(o_mixer_power),
	.o_external_lo_route_power(o_external_lo_route_power),
	.o_lo_driver_power(o_lo_driver_power), .o_ref_buffer_power(o_ref_buffer_power),
	.o_oscillator_power(o_oscillator_power), .o_divider_power(o_divider_power),
	.o_pump_power(o_pump_power), .o_oscillator_regulator_power(o_oscillator_regulator_power),
	.o_main_regulator_power(o_main_regulator_power), .o_div_integer_mode(o_div_integer_mode),
	.o_feedback_integer(o_feedback_integer), .o_feedback_fraction(o_feedback_fraction),
	.o_feedback_modulus(o_feedback_modulus), .o_pump_current_code(o_pump_current_code),
	.o_pump_code_legal(o_pump_code_legal), .o_bleed_source(o_bleed_source),
	.o_bleed_magnitude(o_bleed_magnitude)
);
`default_nettype wire

// ===== rmsc_regs_bench.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/10ps
`default_nettype none
module rmsc_regs_bench;
	logic        i_clk;
	logic        i_rst;
	wire         sclk, cs_n, sdio_line, dev_sdio, dev_oe, soft_pulse, legal;
	wire  [15:0] pwr;
	wire  [11:0] intreg;
	wire  [10:0] frac, modv;
	wire  [13:0] cpreg;
	wire  [127:0] img;
	int          num_errors = 0;
	int          comparisons = 0;
	int          soft_cnt = 0;
	logic [6:0]  ofs [15] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h20, 7'h21, 7'h22,
		7'h23, 7'h30, 7'h31, 7'h40, 7'h42, 7'h43, 7'h05};
	logic [15:0] dflt [15] = '{16'h0000, 16'h8b7f, 16'h0058, 16'h0250, 16'h0600, 16'h0c26,
		16'h0003, 16'h000a, 16'h0000, 16'h0000, 16'h08ef, 16'h0010, 16'h000e, 16'h0001,
		16'h0000};
	assign {pwr[14:12], pwr[10], pwr[6]} = 5'h00;
	assign cpreg[9:6] = 4'h0;
	assign {img[15:7], img[31:25], img[22:21], img[47:44], img[63:56], img[52], img[48],
		img[79:76], img[68], img[95:87], img[111:100]} = 58'h0;
	initial i_clk = 1'b0;
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk)
		if (soft_pulse === 1'b1)
			soft_cnt <= soft_cnt + 1;

	rmsc_host u_host (.i_clk(i_clk), .i_dev_sdio(dev_sdio), .i_dev_sdio_oe(dev_oe),
		.o_sclk(sclk), .o_cs_n(cs_n), .o_sdio(sdio_line));
	rmsc_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n),
		.i_sdio(sdio_line), .o_sdio(dev_sdio), .o_sdio_oe(dev_oe), .o_soft_reset(soft_pulse),
		.o_lo_regulator_power(pwr[15]), .o_output_amplifier_power(pwr[11]),
		.o_mixer_power(pwr[9]), .o_external_lo_route_power(pwr[8]), .o_lo_driver_power(pwr[7]),
		.o_ref_buffer_power(pwr[5]), .o_oscillator_power(pwr[4]), .o_divider_power(pwr[3]),
		.o_pump_power(pwr[2]), .o_oscillator_regulator_power(pwr[1]),
		.o_main_regulator_power(pwr[0]), .o_div_integer_mode(intreg[11]),
		.o_feedback_integer(intreg[10:0]), .o_feedback_fraction(frac),
		.o_feedback_modulus(modv), .o_pump_current_code(cpreg[13:10]),
		.o_pump_code_legal(legal), .o_bleed_source(cpreg[5]), .o_bleed_magnitude(cpreg[4:0]),
		.o_ref_out_select(img[6:4]), .o_pd_negative(img[3]), .o_ref_in_divide(img[2:0]),
		.o_pd_control_two(img[86:80]), .o_lo_drive_level(img[24:23]), .o_lo_divide(img[20:19]),
		.o_osc_select(img[18:16]), .o_switch_pin_ctl(img[43]), .o_rf_input_select(img[42:41]),
		.o_rf_atten(img[40:37]), .o_if_atten(img[36:32]), .o_xfmr_cout(img[55:53]),
		.o_xfmr_cin(img[51:49]), .o_mixer_bias(img[75:73]), .o_mixer_rdac(img[72:69]),
		.o_mixer_cdac(img[67:64]), .o_noise_control(img[99:96]), .o_noise_seed(img[127:112]));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		logic [15:0] unused;
		u_host.xfer(1'b0, a, d, 5, unused);
	endtask
	task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
		logic [15:0] q;
		u_host.xfer(1'b1, a, 16'h0000, 6, q);
		chk($sformatf("readback %h", a), exp, q);
	endtask
	task automatic close_out;
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_values;
		for (int i = 0; i < 15; i++)
			rdchk(ofs[i], dflt[i]);
		chk("power outputs", 16'h8b3f, pwr);
		chk("pump outputs", 16'h0c26, {2'h0, cpreg});
		$display("test reset values done");
	endtask
	task automatic t_power;
		wr(7'h01, 16'h0000);
		chk("power cleared", 16'h0000, pwr);
		wr(7'h01, 16'h8b7b);
		chk("pump power off", 16'h8b3b, pwr);
		wr(7'h01, 16'h8a7f);
		chk("external route off", 16'h8a3f, pwr);
		wr(7'h01, 16'hffff);
		chk("power set", 16'h8bbf, pwr);
		rdchk(7'h01, 16'h8bff);
		$display("test power done");
	endtask
	task automatic t_divider;
		wr(7'h02, 16'hffff);
		chk("integer mode", 16'h0fff, {4'h0, intreg});
		rdchk(7'h02, 16'h0fff);
		wr(7'h02, 16'h0123);
		chk("fractional mode", 16'h0123, {4'h0, intreg});
		wr(7'h03, 16'hfaaa);
		chk("fraction", 16'h02aa, {5'h00, frac});
		rdchk(7'h03, 16'h02aa);
		wr(7'h04, 16'h0555);
		chk("modulus", 16'h0555, {5'h00, modv});
		rdchk(7'h04, 16'h0555);
		$display("test divider done");
	endtask
	task automatic t_pump;
		logic [3:0]  codes [5] = '{4'h1, 4'h3, 4'h7, 4'hf, 4'h2};
		logic [15:0] d;
		for (int i = 0; i < 5; i++) begin
			d = {2'h3, codes[i], 4'hf, i[0], codes[i], 1'b1};
			wr(7'h20, d);
			chk("pump fields", d & 16'h3c3f, {2'h0, cpreg});
			chk("legal flag", {15'h0000, i < 4}, {15'h0000, legal});
		end
		rdchk(7'h20, d & 16'h3c3f);
		$display("test pump done");
	endtask
	task automatic t_others;
		logic [15:0] m [8] = '{16'h007f, 16'h019f, 16'h0fff, 16'h00ee, 16'h0fef, 16'h007f,
			16'h000f, 16'hffff};
		for (int i = 0; i < 8; i++) begin
			wr(ofs[i+6], 16'hffff);
			chk("field outputs", m[i], img[16*i +: 16]);
		end
		$display("test other fields done");
	endtask
	task automatic t_soft_reset;
		wr(7'h43, 16'h1234);
		wr(7'h00, 16'hfffe);
		chk("no pulse", 16'h0000, 16'(soft_cnt));
		chk("integer kept", 16'h0123, {4'h0, intreg});
		wr(7'h00, 16'h0001);
		chk("one pulse", 16'h0001, 16'(soft_cnt));
		chk("power restored", 16'h8b3f, pwr);
		chk("integer restored", 16'h0058, {4'h0, intreg});
		chk("fraction restored", 16'h0250, {5'h00, frac});
		chk("modulus restored", 16'h0600, {5'h00, modv});
		chk("pump restored", 16'h0c26, {2'h0, cpreg});
		for (int i = 0; i < 8; i++)
			chk("fields restored", dflt[i+6], img[16*i +: 16]);
		rdchk(7'h43, 16'h0001);
		wr(7'h05, 16'hffff);
		rdchk(7'h05, 16'h0000);
		$display("test soft reset done");
	endtask

	initial begin
		repeat (60000) @(posedge i_clk);
		num_errors++;
		close_out();
	end
	initial begin
		i_rst = 1'b1;
		repeat (20) @(posedge i_clk);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_clk);
		t_reset_values();
		t_power();
		t_divider();
		t_pump();
		t_others();
		t_soft_reset();
		close_out();
	end
endmodule // rmsc_regs_bench
`default_nettype wire

// ===== rmsc_serial.v
// Three-wire serial slave that carries frames to and from the register bank
`timescale 1ns/10ps
`default_nettype none
`include "rmsc_defines.vh"

module rmsc_serial (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_rst,
	// Serial pins
	input  wire        i_sclk,
	input  wire        i_cs_n,
	input  wire        i_sdio,
	output wire        o_sdio,
	output wire        o_sdio_oe,
	// Register side
	input  wire [15:0] i_rdata,
	output wire [6:0]  o_addr,
	output wire [15:0] o_wdata,
	output wire        o_wr_stb,
	output wire        o_rd_stb
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	reg [2:0]  sclk_q;
	reg [1:0]  cs_q;
	reg [1:0]  din_q;
	reg [4:0]  cnt_q;
	reg [22:0] sh_q;
	reg [6:0]  addr_q;
	reg [15:0] wdata_q;
	reg [15:0] tx_q;
	reg        rd_q;
	reg        wr_stb_q;
	reg        rd_stb_q;
	reg        load_q;
	reg        dout_q;
	reg        oe_q;
	wire       rise;
	wire       fall;

	// Edge detection reads only the second and third stages
	assign rise = sclk_q[1] & ~sclk_q[2];
	assign fall = ~sclk_q[1] & sclk_q[2];

	// ----------------------------------------------------------------
	// Frame engine
	// ----------------------------------------------------------------
	always @(posedge i_clk) begin
		if (i_rst) begin
			sclk_q   <= 3'h0;
			cs_q     <= 2'h3;
			din_q    <= 2'h0;
			cnt_q    <= 5'h0;
			sh_q     <= 23'h0;
			addr_q   <= 7'h0;
			wdata_q  <= 16'h0000;
			tx_q     <= 16'h0000;
			rd_q     <= 1'b0;
			wr_stb_q <= 1'b0;
			rd_stb_q <= 1'b0;
			load_q   <= 1'b0;
			dout_q   <= 1'b0;
			oe_q     <= 1'b0;
		end else begin
			sclk_q   <= {sclk_q[1:0], i_sclk};
			cs_q     <= {cs_q[0], i_cs_n};
			din_q    <= {din_q[0], i_sdio};
			wr_stb_q <= 1'b0;
			rd_stb_q <= 1'b0;
			load_q   <= rd_stb_q;
			if (load_q)
				tx_q <= i_rdata;
			// Deselect aborts a short frame: nothing is written
			if (cs_q[1]) begin
				cnt_q <= 5'h0;
				rd_q  <= 1'b0;
				oe_q  <= 1'b0;
			end else begin
				if (rise && cnt_q < `RMSC_FRAME_BITS) begin
					sh_q  <= {sh_q[21:0], din_q[1]};
					cnt_q <= cnt_q + 5'h1;
					if (cnt_q == `RMSC_HDR_LAST) begin
						addr_q   <= {sh_q[5:0], din_q[1]};
						rd_q     <= sh_q[6];
						rd_stb_q <= sh_q[6];
					end
					if (cnt_q == `RMSC_DATA_LAST && !rd_q) begin
						wdata_q  <= {sh_q[14:0], din_q[1]};
						wr_stb_q <= 1'b1;
					end
				end
				// Read data leaves on falling edges once the header is in
				if (fall && rd_q) begin
					oe_q   <= 1'b1;
					dout_q <= tx_q[15];
					tx_q   <= {tx_q[14:0], 1'b0};
				end
			end
		end
	end

	assign o_sdio    = dout_q;
	assign o_sdio_oe = oe_q;
	assign o_addr    = addr_q;
	assign o_wdata   = wdata_q;
	assign o_wr_stb  = wr_stb_q;
	assign o_rd_stb  = rd_stb_q;

endmodule // rmsc_serial

`default_nettype wire
